// *** hdl/cbt_top.v ***
// Bit-timing configuration, error and status register, and interrupt logic of the bus controller.
// Functional notes
// - The first time segment is a four-bit field used as its value plus one quanta.
// - The first time segment spans the propagation and first phase segments together.
// - The second time segment is a three-bit field used as its value plus one quanta.
// - The second segment is the phase after the sample point, one to eight quanta long.
// - Bit length comes from both segments and the prescaler; all nodes share one bit rate.
// - Once any error flag is set, all other error flags are frozen.
// - Writing one to a set error flag clears it and lets the register update again.
// - Error and state flags sit in bits 24 down to 16 of the status register.
// - Suspend, config-change, power-down, receiving and transmitting bits sit at 5, 4, 3, 1 and 0.
// - After reset only the stuck-dominant flag and config-change bit read one.
// - The baud prescaler is used as its value plus one clocks per quantum.
// - Stuck-dominant is set by resets or detachment and cleared when a recessive bit is seen.
`timescale 1ns/1ps
`include "cbt_defines.vh"
module cbt_top (
  input wire clk_in,
  input wire resetn_in,
  input wire [7:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output wire [31:0] rd_data_out,
  output wire irq_out,
  input wire soft_reset_in,
  input wire bus_rx_in,
  input wire form_error_in,
  input wire bit_error_in,
  input wire checksum_error_in,
  input wire stuff_error_in,
  input wire acknowledge_error_in,
  input wire detached_from_bus_in,
  input wire error_passive_state_in,
  input wire error_warning_state_in,
  input wire suspend_acknowledge_in,
  input wire config_change_allowed_in,
  input wire power_down_acknowledge_in,
  input wire receiving_flag_in,
  input wire transmitting_flag_in,
  output wire tq_tick_out,
  output wire sample_point_out,
  output wire bit_start_out,
  output wire sampled_bit_out,
  output wire triple_sample_out,
  output wire [1:0] resync_jump_width_out
);
  // Error flag vector order: form, bit, checksum, stuff, acknowledge, detached, passive, warning.
  reg [7:0] err_q;
  reg [7:0] err_d;
  reg stuck_q;
  reg stuck_d;
  reg [31:0] btc_q;
  reg [4:0] state_q;
  reg [`CBT_INT_WIDTH-1:0] int_sts_q;
  reg [`CBT_INT_WIDTH-1:0] int_sts_d;
  reg [`CBT_INT_WIDTH-1:0] int_en_q;
  reg [31:0] rd_data_q;
  reg irq_q;
  reg sampled_bit_q;
  wire [7:0] err_events;
  wire [7:0] err_clear;
  wire frozen;
  wire rx_level;
  wire sample_pulse;
  wire recessive_seen;
  wire wr_btc;
  wire wr_es;
  wire wr_int_en;
  wire wr_int_clr;
  wire [31:0] es_view;

  // Bus receive pin is synchronised before any use.
  cbt_rx_sync u_rx_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_in(bus_rx_in),
    .level_out(rx_level)
  );

  // Bit timing runs only while configuration changes are locked out.
  cbt_bit_timer u_bit_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(~config_change_allowed_in),
    .baud_prescaler_in(btc_q[`CBT_BTC_BRP_HI:`CBT_BTC_BRP_LO]),
    .first_time_segment_in(btc_q[`CBT_BTC_FIRST_TIME_SEGMENT_HI:`CBT_BTC_FIRST_TIME_SEGMENT_LO]),
    .second_time_segment_in(btc_q[`CBT_BTC_SECOND_TIME_SEGMENT_HI:`CBT_BTC_SECOND_TIME_SEGMENT_LO]),
    .tq_tick_out(tq_tick_out),
    .sample_point_out(sample_pulse),
    .bit_start_out(bit_start_out)
  );

  assign sample_point_out = sample_pulse;

  // Register write decode.
  assign wr_btc = wr_en_in && (addr_in == `CBT_OFF_BIT_TIMING_CONFIG);
  assign wr_es = wr_en_in && (addr_in == `CBT_OFF_ERROR_AND_STATUS);
  assign wr_int_en = wr_en_in && (addr_in == `CBT_OFF_INT_ENABLE);
  assign wr_int_clr = wr_en_in && (addr_in == `CBT_OFF_INT_CLEAR);

  // Hardware error events and state levels that try to set the error flags.
  assign err_events = {form_error_in, bit_error_in, checksum_error_in, stuff_error_in,
    acknowledge_error_in, detached_from_bus_in, error_passive_state_in, error_warning_state_in};

  // Only ones written at flag positions clear; zeros and reserved bits do nothing.
  assign err_clear = wr_es ? {wr_data_in[`CBT_ES_FORM], wr_data_in[`CBT_ES_BIT], wr_data_in[`CBT_ES_CRC],
    wr_data_in[`CBT_ES_STUFF], wr_data_in[`CBT_ES_ACK], wr_data_in[`CBT_ES_DETACHED],
    wr_data_in[`CBT_ES_PASSIVE], wr_data_in[`CBT_ES_WARNING]} : 8'h00;

  // Flags stay frozen while any flag survives this cycle's acknowledge.
  assign frozen = |(err_q & ~err_clear);

  // A recessive level at the sample point.
  assign recessive_seen = sample_pulse && rx_level;

  // Next value of the error flags and stuck-dominant flag.
  always @* begin
    err_d = (err_q & ~err_clear) | (frozen ? 8'h00 : err_events); // Set wins over a same-cycle clear unless another flag stays set.
    stuck_d = stuck_q;
    if (recessive_seen) begin
      stuck_d = 1'b0;
    end
    if (soft_reset_in || detached_from_bus_in) begin
      stuck_d = 1'b1;
    end
  end

  // Error flags, stuck-dominant flag and mirrored state bits.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      err_q <= `CBT_ERR_FLAGS_RESET;
      stuck_q <= `CBT_STUCK_RESET;
      state_q <= `CBT_STATE_RESET; // Config-change bit reads one from reset.
    end else begin
      err_q <= soft_reset_in ? `CBT_ERR_FLAGS_RESET : err_d;
      stuck_q <= stuck_d;
      state_q <= {suspend_acknowledge_in, config_change_allowed_in, power_down_acknowledge_in,
        receiving_flag_in, transmitting_flag_in};
    end
  end

  // Status register image; reserved ranges read zero.
  assign es_view = {7'h00, err_q[7], err_q[6], stuck_q, err_q[5], err_q[4], err_q[3], err_q[2],
    err_q[1], err_q[0], 10'h000, state_q[4], state_q[3], state_q[2], 1'b0, state_q[1], state_q[0]};

  // Bit-timing configuration accepts writes only while configuration changes are allowed.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      btc_q <= `CBT_BTC_RESET;
    end else if (wr_btc && config_change_allowed_in) begin
      btc_q <= {8'h00, wr_data_in[`CBT_BTC_BRP_HI:`CBT_BTC_BRP_LO], 6'h00,
        wr_data_in[`CBT_BTC_SJW_HI:`CBT_BTC_SJW_LO], wr_data_in[`CBT_BTC_SAM],
        wr_data_in[`CBT_BTC_FIRST_TIME_SEGMENT_HI:`CBT_BTC_FIRST_TIME_SEGMENT_LO], wr_data_in[`CBT_BTC_SECOND_TIME_SEGMENT_HI:`CBT_BTC_SECOND_TIME_SEGMENT_LO]};
    end
  end

  // Interrupt status: sticky, set wins over a write-one clear.
  always @* begin
    int_sts_d = int_sts_q;
    if (wr_int_clr) begin
      int_sts_d = int_sts_d & ~wr_data_in[`CBT_INT_WIDTH-1:0];
    end
    if (|(err_d & ~err_q)) begin
      int_sts_d[`CBT_INT_ERROR_RECORDED] = 1'b1;
    end
    if (stuck_q && !stuck_d) begin
      int_sts_d[`CBT_INT_RECESSIVE_SEEN] = 1'b1;
    end
  end

  // Interrupt registers and level output.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      int_sts_q <= {`CBT_INT_WIDTH{1'b0}};
      int_en_q <= {`CBT_INT_WIDTH{1'b0}};
      irq_q <= 1'b0;
    end else begin
      int_sts_q <= int_sts_d;
      if (wr_int_en) begin
        int_en_q <= wr_data_in[`CBT_INT_WIDTH-1:0];
      end
      irq_q <= |(int_sts_d & (wr_int_en ? wr_data_in[`CBT_INT_WIDTH-1:0] : int_en_q));
    end
  end

  // Read data stands for one cycle after the strobe; unmapped addresses read zero.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_data_q <= 32'h0000_0000;
    end else if (rd_en_in) begin
      case (addr_in)
        `CBT_OFF_BIT_TIMING_CONFIG: rd_data_q <= btc_q;
        `CBT_OFF_ERROR_AND_STATUS: rd_data_q <= es_view;
        `CBT_OFF_INT_ENABLE: rd_data_q <= {{(32-`CBT_INT_WIDTH){1'b0}}, int_en_q};
        `CBT_OFF_INT_STATUS: rd_data_q <= {{(32-`CBT_INT_WIDTH){1'b0}}, int_sts_q};
        default: rd_data_q <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  // Bus level captured at each sample point.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      sampled_bit_q <= 1'b1;
    end else if (sample_pulse) begin
      sampled_bit_q <= rx_level;
    end
  end

  assign rd_data_out = rd_data_q;
  assign irq_out = irq_q;
  assign sampled_bit_out = sampled_bit_q;
  assign triple_sample_out = btc_q[`CBT_BTC_SAM];
  assign resync_jump_width_out = btc_q[`CBT_BTC_SJW_HI:`CBT_BTC_SJW_LO];
endmodule // cbt_top

// *** hdl/cbt_defines.vh ***
// Register offsets, field positions and reset values of the bit-timing and status block.
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH

// Register byte offsets.
`define CBT_OFF_BIT_TIMING_CONFIG 8'h00
`define CBT_OFF_ERROR_AND_STATUS 8'h04
`define CBT_OFF_INT_ENABLE 8'h08
`define CBT_OFF_INT_CLEAR 8'h0c
`define CBT_OFF_INT_STATUS 8'h10

// Bit-timing configuration fields.
`define CBT_BTC_BRP_HI 23
`define CBT_BTC_BRP_LO 16
`define CBT_BTC_SJW_HI 9
`define CBT_BTC_SJW_LO 8
`define CBT_BTC_SAM 7
`define CBT_BTC_FIRST_TIME_SEGMENT_HI 6
`define CBT_BTC_FIRST_TIME_SEGMENT_LO 3
`define CBT_BTC_SECOND_TIME_SEGMENT_HI 2
`define CBT_BTC_SECOND_TIME_SEGMENT_LO 0
`define CBT_BTC_RESET 32'h0000_0000

// Error and status register fields.
`define CBT_ES_FORM 24
`define CBT_ES_BIT 23
`define CBT_ES_STUCK 22
`define CBT_ES_CRC 21
`define CBT_ES_STUFF 20
`define CBT_ES_ACK 19
`define CBT_ES_DETACHED 18
`define CBT_ES_PASSIVE 17
`define CBT_ES_WARNING 16
`define CBT_ES_SUSPEND_ACK 5
`define CBT_ES_CONFIG_CHANGE 4
`define CBT_ES_POWER_DOWN_ACK 3
`define CBT_ES_RECEIVING 1
`define CBT_ES_TRANSMITTING 0
`define CBT_ERR_FLAGS_RESET 8'h00
`define CBT_STUCK_RESET 1'b1
// Mirrored state bits after reset: only the config-change bit is one.
`define CBT_STATE_RESET 5'h08

// Interrupt status bits.
`define CBT_INT_ERROR_RECORDED 0
`define CBT_INT_RECESSIVE_SEEN 1
`define CBT_INT_WIDTH 2

`endif

// *** hdl/cbt_rx_sync.v ***
// Three-stage synchroniser for the bus receive pin with agreement filter.
`timescale 1ns/1ps
module cbt_rx_sync (
  input wire clk_in,
  input wire resetn_in,
  input wire pin_in,
  output wire level_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;

  // The first stage feeds only the second; a change counts once stages two and three agree.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level_out = level_q;
endmodule // cbt_rx_sync

// *** hdl/cbt_bit_timer.v ***
// Nominal bit timing generator: time-quantum prescaler and segment counter.
`timescale 1ns/1ps
module cbt_bit_timer (
  input wire clk_in,
  input wire resetn_in,
  input wire run_in,
  input wire [7:0] baud_prescaler_in,
  input wire [3:0] first_time_segment_in,
  input wire [2:0] second_time_segment_in,
  output wire tq_tick_out,
  output wire sample_point_out,
  output wire bit_start_out
);
  reg [7:0] pre_q;
  reg [4:0] quantum_q;
  reg tick_q;
  reg sample_q;
  reg start_q;
  wire [4:0] sample_idx;
  wire [4:0] last_idx;
  wire tick_now;

  // Quantum index 0 is the sync quantum, then the first segment, then the second.
  assign sample_idx = {1'b0, first_time_segment_in} + 5'h01;
  assign last_idx = {1'b0, first_time_segment_in} + {2'b00, second_time_segment_in} + 5'h02;
  assign tick_now = run_in && (pre_q == baud_prescaler_in); // Stored prescaler plus one clocks per quantum.

  // Count clocks into quanta and quanta into bits.
  always @(posedge clk_in) begin
    if (!resetn_in || !run_in) begin
      pre_q <= 8'h00;
      quantum_q <= 5'h00;
      tick_q <= 1'b0;
      sample_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      pre_q <= tick_now ? 8'h00 : pre_q + 8'h01;
      tick_q <= tick_now;
      sample_q <= tick_now && (quantum_q == sample_idx); // Sample between first and second segment.
      start_q <= tick_now && (quantum_q == last_idx); // Second segment is stored value plus one quanta.
      if (tick_now) begin
        quantum_q <= (quantum_q == last_idx) ? 5'h00 : quantum_q + 5'h01;
      end
    end
  end

  assign tq_tick_out = tick_q;
  assign sample_point_out = sample_q;
  assign bit_start_out = start_q;
endmodule // cbt_bit_timer

// *** sim/cbt_bus_node.sv ***
// Model of another node on the shared bus.
`timescale 1ns/1ps
module cbt_bus_node (
  input wire clk_in,
  input wire dominant_in,
  output logic bus_out
);
  initial bus_out = 1'b1;
  // Wired-and bus: recessive one unless pulled dominant, updated at every rising clock edge.
  always @(posedge clk_in) begin
    bus_out <= !dominant_in;
  end
endmodule // cbt_bus_node

// *** sim/cbt_monitor.sv ***
// Checker of the register port and bit timer outputs.
`timescale 1ns/1ps
module cbt_monitor (
  input wire clk_in,
  input wire resetn_in,
  input wire [7:0] addr_in,
  input wire rd_en_in,
  input wire [31:0] rd_data_out,
  input wire irq_out,
  input wire soft_reset_in,
  input wire config_change_allowed_in,
  input wire receiving_flag_in,
  input wire transmitting_flag_in,
  input wire tq_tick_out,
  input wire sample_point_out,
  input wire bit_start_out,
  input wire sampled_bit_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_rst;
    disable iff (1'b0) !resetn_in |=> rd_data_out == 32'h0 && !irq_out && !tq_tick_out && sampled_bit_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_unmap;
    rd_en_in && (addr_in == 8'h0c || addr_in > 8'h10) |=> rd_data_out == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_es_rsvd;
    rd_en_in && addr_in == 8'h04 |=> rd_data_out[31:25] == 7'h0 && rd_data_out[15:6] == 10'h0 && !rd_data_out[2];
  endproperty
  a_es_rsvd: assert property (p_es_rsvd) else $error("status reserved bit set");
  property p_btc_rsvd;
    rd_en_in && addr_in == 8'h00 |=> rd_data_out[31:24] == 8'h0 && rd_data_out[15:10] == 6'h0;
  endproperty
  a_btc_rsvd: assert property (p_btc_rsvd) else $error("config reserved bit set");
  property p_mirror;
    $past(resetn_in) && rd_en_in && addr_in == 8'h04 && $stable(receiving_flag_in) && $stable(transmitting_flag_in)
      |=> rd_data_out[1:0] == $past({receiving_flag_in, transmitting_flag_in});
  endproperty
  a_mirror: assert property (p_mirror) else $error("state bits not mirrored");
  property p_sp_bs;
    sample_point_out |-> !bit_start_out;
  endproperty
  a_sp_bs: assert property (p_sp_bs) else $error("sample point at bit end");
  property p_tick;
    sample_point_out || bit_start_out |-> tq_tick_out;
  endproperty
  a_tick: assert property (p_tick) else $error("timer pulse off quantum tick");
  property p_stop;
    config_change_allowed_in [*3] |-> !tq_tick_out && !bit_start_out && !sample_point_out;
  endproperty
  a_stop: assert property (p_stop) else $error("timer runs while stopped");
  property p_stuck;
    soft_reset_in && $past(soft_reset_in) && rd_en_in && addr_in == 8'h04 |=> rd_data_out[22];
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck flag not set");
  c_bit: cover property (bit_start_out);
  c_irq: cover property ($rose(irq_out));
  c_soft: cover property (soft_reset_in && rd_en_in);
endmodule // cbt_monitor
bind cbt_top cbt_monitor mon_u (.clk_in, .resetn_in, .addr_in, .rd_en_in, .rd_data_out, .irq_out, .soft_reset_in,
  .config_change_allowed_in, .receiving_flag_in, .transmitting_flag_in, .tq_tick_out, .sample_point_out,
  .bit_start_out, .sampled_bit_out);

// *** sim/tb_top.sv ***
// Self-checking bench of the bit-timing, status and interrupt block.
`timescale 1ns/1ps
module tb_top;
  localparam int BAUD_PRESCALER = 1, T1 = 2, T2 = 1;
  logic clk_in, resetn_in, wr_en_in, rd_en_in, soft_reset_in, dom, bus_rx_in, irq_out, tq_tick_out;
  logic sample_point_out, bit_start_out, sampled_bit_out, triple_sample_out;
  logic [1:0] resync_jump_width_out;
  logic [7:0] addr_in, ev;
  logic [4:0] st;
  logic [31:0] wr_data_in, rd_data_out, rd_q;
  int err_count, samples_checked, n;
  int pos [8] = '{24, 23, 21, 20, 19, 18, 17, 16};
  cbt_top dut_u (.clk_in, .resetn_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .irq_out,
    .soft_reset_in, .bus_rx_in, .form_error_in(ev[0]), .bit_error_in(ev[1]), .checksum_error_in(ev[2]),
    .stuff_error_in(ev[3]), .acknowledge_error_in(ev[4]), .detached_from_bus_in(ev[5]),
    .error_passive_state_in(ev[6]), .error_warning_state_in(ev[7]), .suspend_acknowledge_in(st[4]),
    .config_change_allowed_in(st[3]), .power_down_acknowledge_in(st[2]), .receiving_flag_in(st[1]),
    .transmitting_flag_in(st[0]), .tq_tick_out, .sample_point_out, .bit_start_out, .sampled_bit_out,
    .triple_sample_out, .resync_jump_width_out);
  cbt_bus_node node_u (.clk_in, .dominant_in(dom), .bus_out(bus_rx_in));
  // Clock of 10 ns.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 rd_q = rd_data_out;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev <= 8'h00;
  endtask
  // Counts cycles up to the next sample point or bit end.
  task automatic wait_pulse(input bit sp);
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while ((sp ? sample_point_out : bit_start_out) !== 1'b1 && n < 300);
    // A timer that never pulses counts as a mismatch.
    if (n >= 300) begin
      err_count++;
      $display("unexpected at %0t: no timer pulse", $time);
    end
  endtask
  task automatic final_report;
    $display("checked %0d, mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  // Test sequence.
  initial begin
    {resetn_in, wr_en_in, rd_en_in, soft_reset_in, dom, addr_in, wr_data_in, ev} = '0;
    st = 5'h08;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(8'h04);
    chk(rd_q, 32'h0040_0010);
    rd(8'h00);
    chk(rd_q, 32'h0);
    rd(8'h14);
    chk(rd_q, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00);
    chk(rd_q, 32'h00ff_03ff);
    chk({triple_sample_out, resync_jump_width_out}, 3'h7);
    @(posedge clk_in);
    st <= 5'h1f;
    rd(8'h04);
    chk(rd_q & 32'h3f, 32'h3b);
    $display("test registers done");
    wr(8'h00, (BAUD_PRESCALER << 16) | (T1 << 3) | T2);
    @(posedge clk_in);
    st <= 5'h00;
    wait_pulse(0);
    wait_pulse(1);
    chk(n, (1 + T1 + 1) * (BAUD_PRESCALER + 1));
    wait_pulse(0);
    chk(n, (T2 + 1) * (BAUD_PRESCALER + 1));
    wait_pulse(0);
    chk(n, (1 + T1 + 1 + T2 + 1) * (BAUD_PRESCALER + 1));
    rd(8'h04);
    chk(rd_q & 32'h0040_0000, 32'h0);
    @(posedge clk_in);
    dom <= 1'b1;
    wait_pulse(0);
    wait_pulse(0);
    chk(sampled_bit_out, 1'b0);
    dom <= 1'b0;
    $display("test timing done");
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      rd(8'h04);
      chk(rd_q & 32'h01bf_0000, 32'h1 << pos[i]);
      wr(8'h04, 32'hffff_ffff);
    end
    pulse(0);
    pulse(2);
    wr(8'h04, 32'h0);
    rd(8'h04);
    chk(rd_q & 32'hffbf_0000, 32'h0100_0000);
    wr(8'h04, 32'h0100_0000);
    pulse(2);
    rd(8'h04);
    chk(rd_q & 32'hffbf_0000, 32'h0020_0000);
    $display("test flags done");
    for (int i = 0; i < 3; i++) begin
      wr(i == 2 ? 8'h0c : 8'h08, i == 1 ? 32'h0 : 32'h1);
      @(posedge clk_in);
      #1 chk(irq_out, i == 0);
    end
    rd(8'h10);
    chk(rd_q & 32'h3, 32'h2);
    $display("test interrupt done");
    @(posedge clk_in);
    st <= 5'h08;
    pulse(3);
    @(posedge clk_in);
    soft_reset_in <= 1'b1;
    rd(8'h04);
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    chk(rd_q & 32'h01ff_0000, 32'h0040_0000);
    $display("test soft reset done");
    // Mid-run hardware reset with a read taken at the first edge after release.
    @(posedge clk_in);
    {st, resetn_in} <= '0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    addr_in <= 8'h04;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 chk(rd_data_out, 32'h0040_0010);
    $display("test hardware reset done");
    final_report();
  end
endmodule // tb_top
